/* File: mcr_defs.vh */
// register offsets, field positions, reset values and timing for the peripheral control bank
`ifndef MCR_DEFS_VH
`define MCR_DEFS_VH

// ==========================================================
// register offsets (byte addresses)
`define MCR_OFS_CMP       8'h00
`define MCR_OFS_TRIM      8'h04
`define MCR_OFS_OPTION    8'h08
`define MCR_OFS_MASK      8'h0c
`define MCR_OFS_PWM       8'h10
`define MCR_OFS_TMR       8'h14
`define MCR_OFS_FLAG      8'h18
`define MCR_OFS_GIE       8'h1c

// ==========================================================
// field positions
`define MCR_CMP_REFN_BIT  7
`define MCR_CMP_RATIO_HI  6
`define MCR_CMP_RATIO_LO  3
`define MCR_CMP_RES_BIT   2
`define MCR_OPT_LVR_HI    5
`define MCR_OPT_LVR_LO    4
`define MCR_OPT_RCM_HI    3
`define MCR_OPT_RCM_LO    2
`define MCR_OPT_ADC_WIDTH_SEL_BIT  1
`define MCR_OPT_WDT_BIT   0
`define MCR_PWM_CAS_BIT   2
`define MCR_PWM_BEN_BIT   1
`define MCR_PWM_AEN_BIT   0
`define MCR_TMR_BEN_BIT   7
`define MCR_TMR_AEN_BIT   6
`define MCR_IRQ_CMP_BIT   7

// ==========================================================
// writable bits and reset values
`define MCR_CMP_WMASK     8'hfb
`define MCR_TRIM_WMASK    8'h1f
`define MCR_OPT_WMASK     8'h3d
`define MCR_MASK_WMASK    8'hbf
`define MCR_PWM_WMASK     8'h07
`define MCR_TMR_WMASK     8'hff
`define MCR_CMP_RST       8'h78
`define MCR_TRIM_RST      8'h1f
`define MCR_OPT_RST       8'h3d
`define MCR_MASK_RST      8'h00
`define MCR_PWM_RST       8'h00
`define MCR_TMR_RST       8'h00

// ==========================================================
// comparator select codes
`define MCR_COS_OFF       2'b00
`define MCR_COS_ON_IO     2'b01
`define MCR_COS_ON_PIN    2'b10

// ==========================================================
// watchdog periods in microseconds, at a 10 ns clock
`define MCR_CLK_NS        10
`define MCR_WDT_LONG_US   18000
`define MCR_WDT_SHORT_US  4500

`endif

/* File: mcr_prescale.v */
// prescaler that turns the system clock into a timer count tick
`timescale 1ns/1ps
module mcr_prescale (
  // clock and reset
  input  wire       clk_i,
  input  wire       rst_i,
  // control
  input  wire       enable_i,
  input  wire [2:0] sel_i,
  // tick out
  output wire       tick_o
);

  // ==========================================================
  // ratio decode: 1,2,4,8,16,64,128,256 (32 is skipped)
  function [7:0] last_count;
    input [2:0] sel;
    begin
      case (sel)
        3'h0:    last_count = 8'h00;
        3'h1:    last_count = 8'h01;
        3'h2:    last_count = 8'h03;
        3'h3:    last_count = 8'h07;
        3'h4:    last_count = 8'h0f;
        3'h5:    last_count = 8'h3f;
        3'h6:    last_count = 8'h7f;
        default: last_count = 8'hff;
      endcase
    end
  endfunction

  reg  [7:0] count_reg;
  wire       wrap;

  assign wrap   = (count_reg >= last_count(sel_i));
  assign tick_o = enable_i & wrap;

  // ==========================================================
  // counter held clear while disabled so a restart runs a full period
  always @(posedge clk_i) begin
    if (rst_i || !enable_i) begin
      count_reg <= 8'h00;
    end else if (wrap) begin
      count_reg <= 8'h00;
    end else begin
      count_reg <= count_reg + 8'h01;
    end
  end

endmodule // mcr_prescale

/* File: mcr_ctrl_regs.v */
// peripheral control register bank with wishbone slave, pin ownership and interrupt gating
//
// Our own choices: the address map and the Wishbone slave port.
`timescale 1ns/1ps
`include "mcr_defs.vh"
module mcr_ctrl_regs #(
  parameter WDT_LONG_CYC  = (`MCR_WDT_LONG_US * 1000) / `MCR_CLK_NS,
  parameter WDT_SHORT_CYC = (`MCR_WDT_SHORT_US * 1000) / `MCR_CLK_NS
) (
  // clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // wishbone slave
  input  wire        cyc_i,
  input  wire        stb_i,
  input  wire        we_i,
  input  wire [7:0]  adr_i,
  input  wire [3:0]  sel_i,
  input  wire [31:0] dat_i,
  output reg  [31:0] dat_o,
  output reg         ack_o,
  // core instruction strobes
  input  wire        global_irq_on_instr_i,
  input  wire        global_irq_off_instr_i,
  // interrupt events, one-cycle pulses
  input  wire        timer_ovf_evt_i,
  input  wire        port_change_evt_i,
  input  wire        ext_evt_i,
  input  wire        adc_done_evt_i,
  input  wire        pwm_a_evt_i,
  input  wire        pwm_b_evt_i,
  output reg         irq_o,
  // comparator
  input  wire        cmp_result_i,
  output reg         cmp_active_o,
  output reg         cmp_neg_pin_io_o,
  output reg  [3:0]  cmp_ref_ratio_o,
  // oscillator, reset and watchdog options
  output reg  [4:0]  osc_trim_o,
  output reg  [1:0]  low_volt_reset_sel_o,
  output reg  [1:0]  int_osc_freq_sel_o,
  output reg  [20:0] wdt_timeout_cyc_o,
  // pwm and timers
  output reg         pwm_cascade_o,
  output reg         pwm_a_enable_o,
  output reg         pwm_b_enable_o,
  output wire        timer_a_tick_o,
  output wire        timer_b_tick_o,
  // shared-pin requests
  input  wire        tcc_pin_use_i,
  input  wire        osc_out_use_i,
  input  wire        osc_clk_i,
  input  wire        adc_on_i,
  input  wire [2:0]  adc_ch_i,
  input  wire        pwm_a_i,
  input  wire        pwm_b_i,
  input  wire [7:0]  port_out_i,
  input  wire [7:0]  port_oe_n_i,
  // pin drive
  output reg  [7:0]  pin_out_o,
  output reg  [7:0]  pin_oe_n_o,
  output reg  [3:0]  pin1_owner_o,
  output reg  [3:0]  pin3_owner_o,
  output reg  [3:0]  pin5_owner_o,
  output reg  [3:0]  pin6_owner_o
);

  // ==========================================================
  // owner codes, highest priority first
  localparam OWN_TOP  = 4'b1000;
  localparam OWN_HIGH = 4'b0100;
  localparam OWN_MED  = 4'b0010;
  localparam OWN_PORT = 4'b0001;

  // one-hot winner among up to three requests over the plain port
  function [3:0] pick_owner;
    input top;
    input high;
    input med;
    begin
      if (top) begin
        pick_owner = OWN_TOP;
      end else if (high) begin
        pick_owner = OWN_HIGH;
      end else if (med) begin
        pick_owner = OWN_MED;
      end else begin
        pick_owner = OWN_PORT;
      end
    end
  endfunction

  // ==========================================================
  // registers
  reg  [7:0] cmp_reg;
  reg  [7:0] trim_reg;
  reg  [7:0] opt_reg;
  reg  [7:0] mask_reg;
  reg  [7:0] pwm_reg;
  reg  [7:0] tmr_reg;
  reg  [7:0] flag_reg;
  reg        gie_reg;
  reg  [7:0] flag_next;
  reg  [7:0] rd_byte;

  // comparator result synchroniser and filter
  reg        cmp_s1_reg;
  reg        cmp_s2_reg;
  reg        cmp_s3_reg;
  reg        cmp_val_reg;

  wire       req;
  wire       wr_stb;
  wire       rd_hit;
  wire       cmp_change;
  wire [7:0] evt_vec;
  wire [7:0] wr_byte;
  wire [1:0] cos;
  wire       cmp_on;
  wire [3:0] own1;
  wire [3:0] own3;
  wire [3:0] own5;
  wire [3:0] own6;
  wire [1:0] tick;

  // ==========================================================
  // bus slave: ack one edge after the request, dropped the next cycle
  assign req     = cyc_i & stb_i & ~ack_o;
  assign wr_stb  = req & we_i & sel_i[0];
  assign wr_byte = dat_i[7:0];

  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= req;
      if (rd_hit) begin
        dat_o <= {24'h00_0000, rd_byte};
      end
    end
  end

  // read mux; unmapped offsets answer with zero
  always @* begin
    case (adr_i)
      `MCR_OFS_CMP:    rd_byte = {cmp_reg[7:3], cmp_val_reg, cmp_reg[1:0]};
      `MCR_OFS_TRIM:   rd_byte = trim_reg & `MCR_TRIM_WMASK;
      `MCR_OFS_OPTION: rd_byte = opt_reg & `MCR_OPT_WMASK;
      `MCR_OFS_MASK:   rd_byte = mask_reg & `MCR_MASK_WMASK;
      `MCR_OFS_PWM:    rd_byte = pwm_reg & `MCR_PWM_WMASK;
      `MCR_OFS_TMR:    rd_byte = tmr_reg;
      `MCR_OFS_FLAG:   rd_byte = flag_reg & mask_reg;
      `MCR_OFS_GIE:    rd_byte = {7'h00, gie_reg};
      default:         rd_byte = 8'h00;
    endcase
  end

  assign rd_hit = req & ~we_i;

  // ==========================================================
  // control registers; read-only and unused bits never store
  always @(posedge clk_i) begin
    if (rst_i) begin
      cmp_reg  <= `MCR_CMP_RST;
      trim_reg <= `MCR_TRIM_RST;
      opt_reg  <= `MCR_OPT_RST;
      mask_reg <= `MCR_MASK_RST;
      pwm_reg  <= `MCR_PWM_RST;
      tmr_reg  <= `MCR_TMR_RST;
    end else if (wr_stb) begin
      case (adr_i)
        `MCR_OFS_CMP:    cmp_reg  <= wr_byte & `MCR_CMP_WMASK;
        `MCR_OFS_TRIM:   trim_reg <= wr_byte & `MCR_TRIM_WMASK;
        `MCR_OFS_OPTION: opt_reg  <= wr_byte & `MCR_OPT_WMASK;
        `MCR_OFS_MASK:   mask_reg <= wr_byte & `MCR_MASK_WMASK;
        `MCR_OFS_PWM:    pwm_reg  <= wr_byte & `MCR_PWM_WMASK;
        `MCR_OFS_TMR:    tmr_reg  <= wr_byte & `MCR_TMR_WMASK;
        default:         cmp_reg  <= cmp_reg;
      endcase
    end
  end

  // ==========================================================
  // global enable driven only by the core's instructions
  always @(posedge clk_i) begin
    if (rst_i) begin
      gie_reg <= 1'b0;
    end else if (global_irq_off_instr_i) begin
      gie_reg <= 1'b0;
    end else if (global_irq_on_instr_i) begin
      gie_reg <= 1'b1;
    end
  end

  // ==========================================================
  // comparator result: three flops, value moves when stages 2 and 3 agree
  always @(posedge clk_i) begin
    if (rst_i) begin
      cmp_s1_reg  <= 1'b0;
      cmp_s2_reg  <= 1'b0;
      cmp_s3_reg  <= 1'b0;
      cmp_val_reg <= 1'b0;
    end else begin
      cmp_s1_reg <= cmp_result_i;
      cmp_s2_reg <= cmp_s1_reg;
      cmp_s3_reg <= cmp_s2_reg;
      if (cmp_s2_reg == cmp_s3_reg) begin
        cmp_val_reg <= cmp_s3_reg;
      end
    end
  end

  // a change only counts while the comparator is in use
  assign cos        = cmp_reg[1:0];
  assign cmp_on     = (cos == `MCR_COS_ON_IO) | (cos == `MCR_COS_ON_PIN);
  assign cmp_change = cmp_on & (cmp_s2_reg == cmp_s3_reg) & (cmp_s3_reg != cmp_val_reg);

  // ==========================================================
  // interrupt flags: write 1 clears, an event in the same cycle wins
  assign evt_vec = {cmp_change, 1'b0, pwm_b_evt_i, pwm_a_evt_i,
                    adc_done_evt_i, ext_evt_i, port_change_evt_i, timer_ovf_evt_i};

  always @* begin
    flag_next = flag_reg;
    if (wr_stb && (adr_i == `MCR_OFS_FLAG)) begin
      flag_next = flag_reg & ~wr_byte;
    end
    flag_next = flag_next | evt_vec;
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      flag_reg <= 8'h00;
      irq_o    <= 1'b0;
    end else begin
      flag_reg <= flag_next & `MCR_MASK_WMASK;
      irq_o    <= gie_reg & |(flag_reg & mask_reg);
    end
  end

  // ==========================================================
  // timer prescalers, one per pwm timer
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_tmr
      mcr_prescale u_pre (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .enable_i (tmr_reg[`MCR_TMR_AEN_BIT + gi]),
        .sel_i    (tmr_reg[gi*3 +: 3]),
        .tick_o   (tick[gi])
      );
    end
  endgenerate

  assign timer_a_tick_o = tick[0];
  assign timer_b_tick_o = tick[1];

  // ==========================================================
  // pin ownership
  assign own5 = pick_owner(tcc_pin_use_i, cmp_on & (cos == `MCR_COS_ON_PIN),
                           adc_on_i & (adc_ch_i == 3'h5));
  assign own3 = pick_owner(1'b0, cmp_on, adc_on_i & (adc_ch_i == 3'h3));
  assign own1 = pick_owner(osc_out_use_i, pwm_reg[`MCR_PWM_AEN_BIT],
                           adc_on_i & (adc_ch_i == 3'h1));
  assign own6 = pick_owner(1'b0, pwm_reg[`MCR_PWM_BEN_BIT],
                           adc_on_i & (adc_ch_i == 3'h6));

  // pin drive is registered; analog and input owners release the pin
  integer k;
  always @(posedge clk_i) begin
    if (rst_i) begin
      pin_out_o  <= 8'h00;
      pin_oe_n_o <= 8'hff;
    end else begin
      for (k = 0; k < 8; k = k + 1) begin
        pin_out_o[k]  <= port_out_i[k];
        pin_oe_n_o[k] <= port_oe_n_i[k];
      end
      case (own1)
        OWN_TOP: begin
          pin_out_o[1]  <= osc_clk_i;
          pin_oe_n_o[1] <= 1'b0;
        end
        OWN_HIGH: begin
          pin_out_o[1]  <= pwm_a_i;
          pin_oe_n_o[1] <= 1'b0;
        end
        OWN_MED: begin
          pin_oe_n_o[1] <= 1'b1;
        end
        default: begin
          pin_oe_n_o[1] <= port_oe_n_i[1];
        end
      endcase
      if (own3 != OWN_PORT) begin
        pin_oe_n_o[3] <= 1'b1;
      end
      case (own5)
        OWN_HIGH: begin
          pin_out_o[5]  <= cmp_val_reg;
          pin_oe_n_o[5] <= 1'b0;
        end
        OWN_PORT: begin
          pin_oe_n_o[5] <= port_oe_n_i[5];
        end
        default: begin
          pin_oe_n_o[5] <= 1'b1;
        end
      endcase
      case (own6)
        OWN_HIGH: begin
          pin_out_o[6]  <= pwm_b_i;
          pin_oe_n_o[6] <= 1'b0;
        end
        OWN_MED: begin
          pin_oe_n_o[6] <= 1'b1;
        end
        default: begin
          pin_oe_n_o[6] <= port_oe_n_i[6];
        end
      endcase
    end
  end

  // ==========================================================
  // field outputs toward the analog and clock blocks
  always @(posedge clk_i) begin
    if (rst_i) begin
      cmp_active_o         <= 1'b0;
      cmp_neg_pin_io_o     <= 1'b1;
      cmp_ref_ratio_o      <= 4'hf;
      osc_trim_o           <= 5'h1f;
      low_volt_reset_sel_o <= 2'h3;
      int_osc_freq_sel_o   <= 2'h3;
      wdt_timeout_cyc_o    <= 21'h00_0000;
      pwm_cascade_o        <= 1'b0;
      pwm_a_enable_o       <= 1'b0;
      pwm_b_enable_o       <= 1'b0;
      pin1_owner_o         <= OWN_PORT;
      pin3_owner_o         <= OWN_PORT;
      pin5_owner_o         <= OWN_PORT;
      pin6_owner_o         <= OWN_PORT;
    end else begin
      cmp_active_o         <= cmp_on;
      // reference enable low keeps the negative input a plain pin
      cmp_neg_pin_io_o     <= ~cmp_reg[`MCR_CMP_REFN_BIT];
      // analog divider gives supply * code / 15
      cmp_ref_ratio_o      <= cmp_reg[`MCR_CMP_RATIO_HI:`MCR_CMP_RATIO_LO];
      osc_trim_o           <= trim_reg[4:0];
      low_volt_reset_sel_o <= opt_reg[`MCR_OPT_LVR_HI:`MCR_OPT_LVR_LO];
      int_osc_freq_sel_o   <= opt_reg[`MCR_OPT_RCM_HI:`MCR_OPT_RCM_LO];
      if (opt_reg[`MCR_OPT_WDT_BIT]) begin
        wdt_timeout_cyc_o <= WDT_LONG_CYC[20:0];
      end else begin
        wdt_timeout_cyc_o <= WDT_SHORT_CYC[20:0];
      end
      pwm_cascade_o        <= pwm_reg[`MCR_PWM_CAS_BIT];
      pwm_a_enable_o       <= pwm_reg[`MCR_PWM_AEN_BIT];
      pwm_b_enable_o       <= pwm_reg[`MCR_PWM_BEN_BIT];
      pin1_owner_o         <= own1;
      pin3_owner_o         <= own3;
      pin5_owner_o         <= own5;
      pin6_owner_o         <= own6;
    end
  end

endmodule // mcr_ctrl_regs

/* File: mcr_ctrl_regs_sva.sv */
// assertion checker for the peripheral control register bank
`timescale 1ns/1ps
module mcr_ctrl_regs_sva #(
  parameter WDT_LONG_CYC  = 180,
  parameter WDT_SHORT_CYC = 45
) (
  // clock, reset and bus
  input wire        clk_i,
  input wire        rst_i,
  input wire        cyc_i,
  input wire        stb_i,
  input wire        we_i,
  input wire [7:0]  adr_i,
  input wire [3:0]  sel_i,
  input wire [31:0] dat_i,
  input wire [31:0] dat_o,
  input wire        ack_o,
  // interrupt
  input wire        global_irq_off_instr_i,
  input wire        irq_o,
  // controls
  input wire        cmp_neg_pin_io_o,
  input wire [3:0]  cmp_ref_ratio_o,
  input wire [4:0]  osc_trim_o,
  input wire [20:0] wdt_timeout_cyc_o,
  input wire        pwm_b_enable_o,
  // pins
  input wire        tcc_pin_use_i,
  input wire        osc_out_use_i,
  input wire        osc_clk_i,
  input wire        pwm_b_i,
  input wire [7:0]  pin_out_o,
  input wire [7:0]  pin_oe_n_o,
  input wire [3:0]  pin1_owner_o,
  input wire [3:0]  pin5_owner_o
);
  // ====
  // helpers
  wire take = cyc_i & stb_i & ~ack_o;
  wire wr   = take & we_i & sel_i[0];

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ====
  // assertions
  AST_ACK_ONE: assert property (take |=> ack_o ##1 !ack_o)
    else $error("ack is not one pulse after a request");
  AST_RST_DEF: assert property ($fell(rst_i) |-> cmp_neg_pin_io_o && cmp_ref_ratio_o == 4'hf)
    else $error("comparator defaults wrong after reset");
  AST_RATIO: assert property (wr && adr_i == 8'h00 |-> ##2
    cmp_ref_ratio_o == $past(dat_i[6:3], 2) && cmp_neg_pin_io_o == !$past(dat_i[7], 2))
    else $error("reference ratio or negative pin not as written");
  AST_TRIM: assert property (wr && adr_i == 8'h04 |-> ##2 osc_trim_o == $past(dat_i[4:0], 2))
    else $error("trim output not as written");
  AST_WDT: assert property (wr && adr_i == 8'h08 |-> ##2
    wdt_timeout_cyc_o == ($past(dat_i[0], 2) ? 21'(WDT_LONG_CYC) : 21'(WDT_SHORT_CYC)))
    else $error("watchdog period does not follow select");
  AST_IRQ_OFF: assert property (global_irq_off_instr_i |-> ##2 !irq_o)
    else $error("request seen with global enable cleared");
  AST_PIN6: assert property (!$past(rst_i) && pwm_b_enable_o && $past(pwm_b_enable_o) |->
    !pin_oe_n_o[6] && pin_out_o[6] == $past(pwm_b_i))
    else $error("pwm b pin not driven by pwm");
  AST_PIN1: assert property (!$past(rst_i) && $past(osc_out_use_i) |->
    pin1_owner_o == 4'b1000 && pin_out_o[1] == $past(osc_clk_i) && !pin_oe_n_o[1])
    else $error("oscillator output does not own pin 1");
  AST_PIN5: assert property (!$past(rst_i) && $past(tcc_pin_use_i) |-> pin5_owner_o == 4'b1000)
    else $error("timer input does not own pin 5");
  AST_DAT_HI: assert property (ack_o |-> dat_o[31:8] == 24'h0)
    else $error("upper read data not zero");

  // ====
  // covers
  COV_WR: cover property (wr);
  COV_IRQ: cover property ($rose(irq_o));
  COV_CO: cover property (pin5_owner_o == 4'b0100);
endmodule // mcr_ctrl_regs_sva

bind mcr_ctrl_regs mcr_ctrl_regs_sva #(.WDT_LONG_CYC(WDT_LONG_CYC), .WDT_SHORT_CYC(WDT_SHORT_CYC)) u_sva (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
  .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .global_irq_off_instr_i(global_irq_off_instr_i), .irq_o(irq_o),
  .cmp_neg_pin_io_o(cmp_neg_pin_io_o), .cmp_ref_ratio_o(cmp_ref_ratio_o), .osc_trim_o(osc_trim_o),
  .wdt_timeout_cyc_o(wdt_timeout_cyc_o), .pwm_b_enable_o(pwm_b_enable_o), .tcc_pin_use_i(tcc_pin_use_i),
  .osc_out_use_i(osc_out_use_i), .osc_clk_i(osc_clk_i), .pwm_b_i(pwm_b_i), .pin_out_o(pin_out_o),
  .pin_oe_n_o(pin_oe_n_o), .pin1_owner_o(pin1_owner_o), .pin5_owner_o(pin5_owner_o));

/* File: mcr_tb.sv */
// self-checking bench for the peripheral control register bank
`timescale 1ns/1ps
module tb;
  localparam LC = 180;
  localparam SC = 45;
  reg         clk_i, rst_i, cyc_i, stb_i, we_i;
  reg  [7:0]  adr_i;
  reg  [3:0]  sel_i;
  reg  [31:0] dat_i, q;
  reg  [1:0]  ins;
  reg  [5:0]  evt;
  reg         cres, tcc, osco, oclk, adc_on, pa, pb;
  reg  [2:0]  adc_ch;
  wire [31:0] dat_o;
  wire        ack_o, irq_o, c_act, neg_io, cas, ae, be, tka, tkb;
  wire [3:0]  ratio, own1, own3, own5, own6;
  wire [4:0]  trim;
  wire [1:0]  lvr, rcm;
  wire [20:0] wdt;
  wire [7:0]  pout, poe_n;
  integer     error_cnt = 0, cmp_count = 0, cyc_n = 0, ta_n = 0, tb_n = 0, a0 = 0, b0 = 0, i, k;
  int         dv[8] = '{1, 2, 4, 8, 16, 64, 128, 256};

  mcr_ctrl_regs #(.WDT_LONG_CYC(LC), .WDT_SHORT_CYC(SC)) u_mcr_ctrl_regs (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .global_irq_on_instr_i(ins[0]), .global_irq_off_instr_i(ins[1]),
    .timer_ovf_evt_i(evt[0]), .port_change_evt_i(evt[1]), .ext_evt_i(evt[2]),
    .adc_done_evt_i(evt[3]), .pwm_a_evt_i(evt[4]), .pwm_b_evt_i(evt[5]), .irq_o(irq_o),
    .cmp_result_i(cres), .cmp_active_o(c_act), .cmp_neg_pin_io_o(neg_io), .cmp_ref_ratio_o(ratio),
    .osc_trim_o(trim), .low_volt_reset_sel_o(lvr), .int_osc_freq_sel_o(rcm), .wdt_timeout_cyc_o(wdt),
    .pwm_cascade_o(cas), .pwm_a_enable_o(ae), .pwm_b_enable_o(be), .timer_a_tick_o(tka),
    .timer_b_tick_o(tkb), .tcc_pin_use_i(tcc), .osc_out_use_i(osco), .osc_clk_i(oclk),
    .adc_on_i(adc_on), .adc_ch_i(adc_ch), .pwm_a_i(pa), .pwm_b_i(pb), .port_out_i(8'h5a),
    .port_oe_n_i(8'h00), .pin_out_o(pout), .pin_oe_n_o(poe_n), .pin1_owner_o(own1),
    .pin3_owner_o(own3), .pin5_owner_o(own5), .pin6_owner_o(own6));

  // ====
  // clock, tick counters, hang guard
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    if (tka === 1'b1) ta_n <= ta_n + 1;
    if (tkb === 1'b1) tb_n <= tb_n + 1;
    if (cyc_n == 30000) begin
      error_cnt = error_cnt + 1;
      wrap_up;
    end
  end

  // ====
  // helpers
  task chk(input string n, input [31:0] e, input [31:0] g);
    cmp_count = cmp_count + 1;
    if (g !== e) begin
      error_cnt = error_cnt + 1;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  // held until ack is sampled, then released for at least one cycle
  task wb(input [7:0] a, input [31:0] d, input w, input s);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= {3'h7, s};
    @(posedge clk_i);
    while (ack_o !== 1'b1) @(posedge clk_i);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  // registered field outputs move one edge after the store, so let it pass
  task wr(input [7:0] a, input [7:0] d);
    wb(a, {24'h0, d}, 1'b1, 1'b1);
    step(1);
  endtask
  task rd(input [7:0] a, input [7:0] e, input string n);
    wb(a, 32'h0, 1'b0, 1'b1);
    chk(n, {24'h0, e}, q);
  endtask
  task step(input integer n);
    repeat (n) @(posedge clk_i);
  endtask
  task strobe(input [1:0] s, input [5:0] e);
    @(posedge clk_i);
    ins <= s;
    evt <= e;
    @(posedge clk_i);
    ins <= 2'b00;
    evt <= 6'h00;
    step(2);
  endtask

  // ====
  // scenarios
  task t_reset;
    rd(8'h00, 8'h78, "cmp");
    rd(8'h04, 8'h1f, "trim");
    rd(8'h08, 8'h3d, "opt");
    rd(8'h0c, 8'h00, "mask");
    rd(8'h10, 8'h00, "pwm");
    rd(8'h14, 8'h00, "tmr");
    rd(8'h18, 8'h00, "flag");
    chk("wdt", LC, wdt);
    $display("t_reset done");
  endtask
  task t_rw;
    wr(8'h00, 8'hff);
    rd(8'h00, 8'hfb, "cmp ro");
    chk("sel 11", 0, c_act);
    wr(8'h04, 8'hff);
    rd(8'h04, 8'h1f, "trim");
    wr(8'h08, 8'hff);
    rd(8'h08, 8'h3d, "opt");
    wr(8'h0c, 8'hff);
    rd(8'h0c, 8'hbf, "mask");
    wr(8'h10, 8'hff);
    rd(8'h10, 8'h07, "pwm");
    wr(8'h14, 8'hff);
    rd(8'h14, 8'hff, "tmr");
    wb(8'h04, 32'h0, 1'b1, 1'b0);
    rd(8'h04, 8'h1f, "no lane");
    wr(8'h20, 8'hff);
    rd(8'h20, 8'h00, "unmapped");
    wr(8'h18, 8'hff);
    rd(8'h18, 8'h00, "flag set");
    wr(8'h00, 8'h28);
    chk("ratio", 4'h5, ratio);
    wr(8'h04, 8'h0a);
    chk("trim out", 5'h0a, trim);
    for (k = 0; k < 6; k++) wr(8'h00 + 4 * k, 8'h00);
    wr(8'h00, 8'h78);
    $display("t_rw done");
  endtask
  task t_opt;
    for (k = 0; k < 4; k++) begin
      wr(8'h08, {2'b00, k[1:0], k[1:0], 1'b0, k[0]});
      rd(8'h08, {2'b00, k[1:0], k[1:0], 1'b0, k[0]}, "opt");
      chk("lvr", k, lvr);
      chk("rcm", k, rcm);
      chk("wdt", k[0] ? LC : SC, wdt);
    end
    $display("t_opt done");
  endtask
  task t_irq;
    strobe(2'b01, 6'h00);
    rd(8'h1c, 8'h01, "gie on");
    for (i = 0; i < 6; i++) begin
      wr(8'h0c, 8'hbf);
      strobe(2'b00, 6'h01 << i);
      chk("irq", 1, irq_o);
      rd(8'h18, 8'h01 << i, "flag");
      wr(8'h0c, 8'h00);
      step(2);
      chk("irq masked", 0, irq_o);
      rd(8'h18, 8'h00, "masked");
      wr(8'h0c, 8'hbf);
      rd(8'h18, 8'h01 << i, "kept");
      wr(8'h18, 8'h01 << i);
      rd(8'h18, 8'h00, "cleared");
    end
    strobe(2'b11, 6'h00);
    rd(8'h1c, 8'h00, "gie off");
    strobe(2'b00, 6'h01);
    chk("irq gie", 0, irq_o);
    wr(8'h18, 8'h01);
    $display("t_irq done");
  endtask
  task t_cmp;
    wr(8'h0c, 8'h80);
    wr(8'h00, 8'h79);
    chk("cmp on", 1, c_act);
    chk("neg io", 1, neg_io);
    chk("own5 io", 4'b0001, own5);
    cres <= 1'b1;
    step(8);
    rd(8'h00, 8'h7d, "result");
    rd(8'h18, 8'h80, "cmp flag");
    wr(8'h18, 8'h80);
    wr(8'h00, 8'h7a);
    step(2);
    chk("own5 co", 4'b0100, own5);
    chk("co out", 1, {poe_n[5], pout[5]});
    tcc <= 1'b1;
    step(3);
    chk("own5 tcc", 4'b1000, own5);
    tcc <= 1'b0;
    adc_on <= 1'b1;
    adc_ch <= 3'd5;
    wr(8'h00, 8'h78);
    chk("own5 an", 4'b0010, own5);
    adc_ch <= 3'd3;
    step(3);
    chk("own3 an", 4'b0010, own3);
    wr(8'h00, 8'h79);
    chk("own3 cmp", 4'b0100, own3);
    adc_on <= 1'b0;
    wr(8'h00, 8'hf8);
    chk("neg ref", 0, neg_io);
    wr(8'h00, 8'h78);
    wr(8'h0c, 8'h00);
    $display("t_cmp done");
  endtask
  task t_pwm;
    pb <= 1'b1;
    adc_on <= 1'b1;
    adc_ch <= 3'd6;
    wr(8'h10, 8'h07);
    chk("pwm ctl", 3'b111, {cas, be, ae});
    chk("pin6", 2'b01, {poe_n[6], pout[6]});
    chk("own6", 4'b0100, own6);
    chk("pin1", 2'b00, {poe_n[1], pout[1]});
    osco <= 1'b1;
    oclk <= 1'b1;
    step(3);
    chk("own1", 4'b1000, own1);
    osco <= 1'b0;
    wr(8'h10, 8'h00);
    chk("own6 an", 4'b0010, own6);
    adc_on <= 1'b0;
    step(3);
    chk("own6 io", 4'b0001, own6);
    chk("own1 io", 4'b0001, own1);
    chk("pin1 io", 1, pout[1]);
    $display("t_pwm done");
  endtask
  task t_tmr;
    for (k = 0; k < 9; k++) begin
      // last pass turns both timers off with the slowest divider
      wr(8'h14, k < 8 ? {2'b11, k[2:0], k[2:0]} : 8'h3f);
      @(negedge clk_i);
      a0 = ta_n;
      b0 = tb_n;
      repeat (512) @(negedge clk_i);
      chk("tick a", k < 8 ? 512 / dv[k] : 0, ta_n - a0);
      chk("tick b", k < 8 ? 512 / dv[k] : 0, tb_n - b0);
    end
    $display("t_tmr done");
  endtask

  task wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    {rst_i, cyc_i, stb_i, we_i, cres, tcc, osco, oclk, adc_on, pa, pb} = 11'h400;
    {adr_i, sel_i, dat_i, ins, evt, adc_ch} = 0;
    step(2);
    rst_i <= 1'b0;
    t_reset;
    t_rw;
    t_opt;
    t_irq;
    t_cmp;
    t_pwm;
    t_tmr;
    wrap_up;
  end
endmodule // tb
